// ===== sim/host_model.sv
/*
  Host model: drives select, serial clock and data MSB first, plus preset and power-down.
  Assumes ref_clk paces it; each pin level lasts at least five ref_clk periods.
*/
`default_nettype none

module host_model (
  // pacing clock
  input  wire logic ref_clk,
  // link and control pins
  output var logic  sclk,
  output var logic  select_n,
  output var logic  serial_in,
  output var logic  preset_n,
  output var logic  power_down_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
    preset_n = 1'b1;
    power_down_n = 1'b1;
  end

  // ----
  // link tasks
  // ----
  // slow levels leave room for a pulled-up chain node
  task automatic lvl();
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic open();
    select_n <= 1'b0;
    lvl();
  endtask
  task automatic shift(input logic b);
    sclk <= 1'b0;
    serial_in <= b;
    lvl();
    sclk <= 1'b1;
    lvl();
  endtask
  // data line shows no stale bit once released
  task automatic close();
    sclk <= 1'b0;
    lvl();
    select_n <= 1'b1;
    serial_in <= ~serial_in;
    lvl();
    lvl();
  endtask
  task automatic word(input logic [9:0] w);
    open();
    for (int i = 9; i >= 0; i--) shift(w[i]);
    close();
  endtask
  task automatic pins(input logic pr, input logic pd);
    preset_n <= pr;
    power_down_n <= pd;
    lvl();
  endtask
endmodule // host_model

`default_nettype wire

// ===== sim/swl_checker.sv
/*
  Checker of pin-to-output relations of the loader.
  Assumes pins are seen about three ref_clk edges after they change.
*/
`default_nettype none

module swl_checker #(
  parameter int CHANNELS = 4
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  reset,
  // pins
  input wire logic                  select_n,
  input wire logic                  preset_n,
  input wire logic                  power_down_n,
  // outputs
  input wire logic                  chain_out,
  input wire logic                  chain_out_oe,
  input wire logic                  terminal_a_open,
  input wire logic                  wiper_to_b,
  input wire logic [CHANNELS*8-1:0] wiper_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [CHANNELS*8-1:0] MID = {CHANNELS{8'h80}};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ----
  // assertions, windows allow the synchroniser lag
  // ----
  chk_pd_opens: assert property (!power_down_n [*4] |-> terminal_a_open && wiper_to_b)
    else $error("power-down did not open terminals");
  chk_pd_release: assert property (power_down_n [*4] |-> !terminal_a_open && !wiper_to_b)
    else $error("terminals open without power-down");
  chk_pd_chain_off: assert property (!power_down_n [*4] |-> !chain_out_oe)
    else $error("chain driver on in power-down");
  chk_chain_drain: assert property (!chain_out)
    else $error("chain output drives high");
  chk_sel_chain: assert property (select_n [*5] |-> !chain_out_oe)
    else $error("chain driver on while deselected");
  chk_preset_mid: assert property (!preset_n [*4] |-> wiper_pos == MID)
    else $error("preset did not force midscale");
  chk_preset_rise: assert property ($rose(preset_n) && select_n && wiper_pos == MID
    |=> wiper_pos == MID [*4])
    else $error("midscale lost after preset release");
  chk_idle_hold: assert property ((select_n && preset_n) [*8] |=> $stable(wiper_pos))
    else $error("wiper changed without select rise");
  chk_preset_chain: assert property (!preset_n [*4] |-> !chain_out_oe)
    else $error("chain driver on during preset");

  cover property (!power_down_n [*4]);
  cover property ($rose(preset_n) && select_n);
  cover property ($rose(select_n));
  cover property (!select_n && chain_out_oe);
endmodule // swl_checker

bind serial_wiper_latch_loader swl_checker #(.CHANNELS(CHANNELS)) swl_checker_inst (
  .ref_clk, .reset, .select_n, .preset_n, .power_down_n, .chain_out, .chain_out_oe,
  .terminal_a_open, .wiper_to_b, .wiper_pos);

`default_nettype wire

// ===== sim/tb_top.sv
/*
  Self-checking bench of the serial wiper latch loader.
  Assumes host_model drives the link pins and swl_checker is bound.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MID = 32'h80808080;
  localparam logic [7:0] CODES [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  localparam logic [9:0] WA = 10'h2B5;
  localparam logic [9:0] WB = 10'h277;
  localparam logic [9:0] WP = 10'h011;

  logic ref_clk = 1'b0;
  logic reset, reg_wr, reg_rd, chain_out, chain_out_oe, terminal_a_open, wiper_to_b;
  logic sclk, select_n, serial_in, preset_n, power_down_n;
  logic [2:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, wiper_pos, v, exp_pos;
  int n_errors = 0;
  int n_checks = 0;
  // open drain with pull-up
  wire logic chain_line = chain_out_oe ? chain_out : 1'b1;

  always #5 ref_clk = ~ref_clk;

  host_model host_model_inst (.ref_clk, .sclk, .select_n, .serial_in, .preset_n,
    .power_down_n);
  serial_wiper_latch_loader #(.CHANNELS(4)) serial_wiper_latch_loader_inst (.ref_clk,
    .reset, .sclk, .select_n, .serial_in, .preset_n, .power_down_n, .chain_out,
    .chain_out_oe, .terminal_a_open, .wiper_to_b, .wiper_pos, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    exp_pos = MID;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(3'h0);
    chk(v, 32'h2);
    rd(3'h7);
    chk(v, 32'h0);
    chk(wiper_pos, MID);
    $display("test reset done");
    for (int a = 0; a < 4; a++) begin
      host_model_inst.word({a[1:0], CODES[a]});
      exp_pos[a*8 +: 8] = CODES[a];
      chk(wiper_pos, exp_pos);
      rd(3'(a + 2));
      chk(v, {24'h0, CODES[a]});
    end
    $display("test channels done");
    host_model_inst.open();
    for (int i = 0; i < 3; i++) host_model_inst.shift(1'b1);
    for (int i = 9; i >= 0; i--) host_model_inst.shift(WB[i] ^ WA[i]);
    rd(3'h1);
    chk(v & 32'h3FF, {22'h0, WB ^ WA});
    host_model_inst.close();
    exp_pos[7:0] = WB[7:0] ^ WA[7:0];
    chk(wiper_pos, exp_pos);
    $display("test last ten done");
    host_model_inst.open();
    for (int i = 9; i >= 0; i--) host_model_inst.shift(WA[i]);
    for (int i = 9; i >= 0; i--) begin
      host_model_inst.shift(WB[i]);
      chk({31'h0, chain_out_oe}, {31'h0, ~WA[i]});
    end
    chk({31'h0, chain_out}, 32'h0);
    rd(3'h6);
    chk(v, 32'h14);
    rd(3'h1);
    chk(v & 32'h3000, 32'h3000);
    host_model_inst.close();
    exp_pos[23:16] = WB[7:0];
    chk(wiper_pos, exp_pos);
    $display("test chain done");
    host_model_inst.pins(1'b1, 1'b0);
    chk({29'h0, terminal_a_open, wiper_to_b, chain_line}, 32'h7);
    host_model_inst.open();
    for (int i = 9; i >= 0; i--) begin
      host_model_inst.shift(WP[i]);
      chk({31'h0, chain_line}, 32'h1);
    end
    host_model_inst.close();
    exp_pos[7:0] = WP[7:0];
    chk(wiper_pos, exp_pos);
    host_model_inst.pins(1'b1, 1'b1);
    chk({30'h0, terminal_a_open, wiper_to_b}, 32'h0);
    $display("test power-down done");
    wr(3'h0, 32'h0);
    rd(3'h0);
    chk(v, 32'h0);
    host_model_inst.word(10'h1EE);
    chk(wiper_pos, exp_pos);
    wr(3'h0, 32'h1);
    host_model_inst.word(10'h2CC);
    chk(wiper_pos, exp_pos);
    host_model_inst.word(10'h1EE);
    exp_pos[15:8] = 8'hEE;
    chk(wiper_pos, exp_pos);
    wr(3'h0, 32'h2);
    $display("test variant done");
    host_model_inst.pins(1'b0, 1'b1);
    chk(wiper_pos, MID);
    host_model_inst.word(10'h099);
    chk(wiper_pos, MID);
    host_model_inst.pins(1'b1, 1'b1);
    chk(wiper_pos, MID);
    $display("test preset done");
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire

// ===== verilog/pin_sync.sv
/*
  Two flip-flop synchroniser for a group of pins.
  Assumes pins are asynchronous to ref_clk; RESET_VAL gives the idle level.
*/
`default_nettype none
`include "wiper_defs.svh"

module pin_sync #(
  parameter int              W         = 1,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset,
  // pins in, synchronised out
  input  wire logic [W-1:0]  pin_in,
  output logic      [W-1:0]  pin_sync_out
);

  if (W < 1) begin : g_bad_width
    $error("W must be at least one");
  end

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // stage1 feeds stage2 only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign pin_sync_out = stage2_ff;

endmodule // pin_sync

`default_nettype wire

// ===== verilog/serial_wiper_latch_loader.sv
/*
  Serial front end of a multi-channel digital potentiometer: shift register,
  wiper latches, preset, power-down and open-drain chain output.
  Assumes all link pins are asynchronous to ref_clk and that the serial clock
  is much slower than ref_clk (each level lasts at least three ref_clk cycles).
*/
`default_nettype none
`include "wiper_defs.svh"

module serial_wiper_latch_loader
  import wiper_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  // serial link and control pins
  input  wire logic                           sclk,
  input  wire logic                           select_n,
  input  wire logic                           serial_in,
  input  wire logic                           preset_n,
  input  wire logic                           power_down_n,
  // open-drain chain output
  output logic                                chain_out,
  output logic                                chain_out_oe,
  // analog switch controls
  output logic                                terminal_a_open,
  output logic                                wiper_to_b,
  output logic [CHANNELS*`SWL_CODE_BITS-1:0]  wiper_pos,
  // register port
  input  wire logic [`SWL_ADDR_BITS-1:0]      reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [31:0]                         reg_rdata
);

  localparam int WB = `SWL_WORD_BITS;
  localparam int CB = `SWL_CODE_BITS;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // latch indexing and the variant decode serve only these counts
  if (CHANNELS != 1 && CHANNELS != 2 && CHANNELS != 4) begin : g_bad_channels
    $error("CHANNELS must be 1, 2 or 4");
  end
  // the two address bits must sit directly above the code
  if (WB != CB + 2) begin : g_bad_word
    $error("word must be the code plus two address bits");
  end
  if (`SWL_DATA_MSB != CB - 1) begin : g_bad_msb
    $error("code field must end at bit zero");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // all five pins share one synchroniser bank
  serial_pins_t pins_raw;
  serial_pins_t pins_s;

  assign pins_raw = '{sclk: sclk, select_n: select_n, serial_in: serial_in,
                      preset_n: preset_n, power_down_n: power_down_n};

  // preset passes here too, so it acts about three cycles late
  pin_sync #(
    .W         ($bits(serial_pins_t)),
    .RESET_VAL (5'h0B)
  ) u_pin_sync (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .pin_in       (pins_raw),
    .pin_sync_out (pins_s)
  );

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  logic        sclk_d_ff;
  logic        select_d_ff;
  logic        preset_d_ff;
  wire  logic  sclk_rise;
  wire  logic  select_rise;
  wire  logic  select_fall;
  wire  logic  preset_rise;
  wire  logic  preset_act;
  wire  logic  pd_act;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_d_ff   <= 1'b0;
      select_d_ff <= 1'b1;
      preset_d_ff <= 1'b1;
    end else begin
      sclk_d_ff   <= pins_s.sclk;
      select_d_ff <= pins_s.select_n;
      preset_d_ff <= pins_s.preset_n;
    end
  end

  // one-cycle pulses, but preset_act and pd_act are levels; idle reset values keep a false edge from following reset
  assign sclk_rise   = pins_s.sclk & ~sclk_d_ff;
  assign select_rise = pins_s.select_n & ~select_d_ff;
  assign select_fall = ~pins_s.select_n & select_d_ff;
  assign preset_rise = pins_s.preset_n & ~preset_d_ff;
  assign preset_act  = ~pins_s.preset_n;
  assign pd_act      = ~pins_s.power_down_n;

  // ------------------------------------------------------------
  // link state
  // ------------------------------------------------------------
  // frame flag only; shifting itself needs no state
  link_state_t state_ff;
  link_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LINK_IDLE: begin
        if (select_fall) begin
          nxt_state = LINK_SHIFT;
        end
      end
      LINK_SHIFT: begin
        if (pins_s.select_n) begin
          nxt_state = LINK_IDLE;
        end
      end
      default: nxt_state = LINK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= LINK_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // shift register
  // ------------------------------------------------------------
  logic [WB-1:0]  shift_reg_ff;
  logic [15:0]    bit_count_ff;
  logic           chain_bit_ff;
  wire  logic     do_shift;
  wire  logic [WB-1:0] nxt_shift_reg;
  wire  logic [15:0]   nxt_bit_count;

  // shifting continues in power-down
  assign do_shift      = ~pins_s.select_n & sclk_rise & ~preset_act;
  // msb first, older bits fall off the top
  assign nxt_shift_reg = {shift_reg_ff[WB-2:0], pins_s.serial_in};
  // saturates rather than wraps, so the aligned flag never lies
  assign nxt_bit_count = (bit_count_ff == 16'hFFFF) ? bit_count_ff
                                                    : bit_count_ff + 16'h0001;

  // sclk low holds the register unchanged
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_reg_ff <= '0;
    end else if (do_shift) begin
      shift_reg_ff <= nxt_shift_reg;
    end
  end

  // oldest bit leaves toward the next device
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      chain_bit_ff <= 1'b0;
    end else if (preset_act) begin
      chain_bit_ff <= 1'b0;
    end else if (do_shift) begin
      chain_bit_ff <= shift_reg_ff[WB-1];
    end
  end

  // counts bits per frame; a whole frame is a multiple of ten
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_count_ff <= '0;
    end else if (select_fall) begin
      // a shift in the opening cycle still counts
      bit_count_ff <= do_shift ? 16'h0001 : 16'h0000;
    end else if (do_shift) begin
      bit_count_ff <= nxt_bit_count;
    end
  end

  // ------------------------------------------------------------
  // address decode and wiper latches
  // ------------------------------------------------------------
  logic [1:0]    variant_ff;
  wiper_code_t   latch_ff [CHANNELS];
  wire  logic [1:0] word_addr;
  wire  logic [2:0] avail_ch;
  wire  logic       addr_ok;
  wire  logic       do_load;

  // the two oldest bits of the word are the address
  assign word_addr = {shift_reg_ff[`SWL_ADDR_HI_POS],
                      shift_reg_ff[`SWL_ADDR_LO_POS]};
  // narrower variants ignore words for absent channels
  // code 3 is reserved and serves as four channels
  assign avail_ch  = (variant_ff == 2'(VARIANT_ONE)) ? 3'h1 :
                     (variant_ff == 2'(VARIANT_TWO)) ? 3'h2 : 3'h4;
  assign addr_ok   = ({1'b0, word_addr} < avail_ch) &&
                     ({1'b0, word_addr} < 3'(CHANNELS));
  // sclk and data play no part in the load itself
  assign do_load   = select_rise & ~preset_act & addr_ok;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_latch
      wire logic hit;
      assign hit = do_load && (word_addr == 2'(ch));
      // power-down does not touch the codes
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          // reset centres too, as if preset had been pulsed
          latch_ff[ch] <= `SWL_MIDSCALE;
        end else if (preset_act || preset_rise) begin
          latch_ff[ch] <= `SWL_MIDSCALE;
        end else if (hit) begin
          latch_ff[ch] <= shift_reg_ff[`SWL_DATA_MSB:0];
        end
      end
      assign wiper_pos[ch*CB +: CB] = latch_ff[ch];
    end
  endgenerate

  // ------------------------------------------------------------
  // power-down and chain output
  // ------------------------------------------------------------
  logic       term_open_ff;
  logic       wiper_b_ff;
  logic       chain_oe_ff;
  wire  logic nxt_chain_oe;

  // pull low only for a zero; a one is left to the pull-up
  assign nxt_chain_oe = ~pins_s.select_n & ~preset_act & ~pd_act &
                        ~chain_bit_ff;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      term_open_ff <= 1'b0;
      wiper_b_ff   <= 1'b0;
      chain_oe_ff  <= 1'b0;
    end else begin
      // both switch controls follow one synchronised level
      term_open_ff <= pd_act;
      wiper_b_ff   <= pd_act;
      chain_oe_ff  <= nxt_chain_oe;
    end
  end

  assign chain_out       = 1'b0;
  assign chain_out_oe    = chain_oe_ff;
  assign terminal_a_open = term_open_ff;
  assign wiper_to_b      = wiper_b_ff;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic [31:0]  rdata_ff;
  logic [31:0]  rd_mux;
  wire  logic   wr_ctrl;
  wire  logic   aligned;
  wire  logic [31:0] status_word;
  wire  logic   frame_open;

  // writes to read-only addresses fall away
  assign wr_ctrl = reg_wr && (reg_addr == `SWL_REG_CTRL);
  assign aligned = (bit_count_ff != 16'h0000) &&
                   ((bit_count_ff % 16'(WB)) == 16'h0000);

  // frame flag reads high from select fall to select rise
  assign frame_open = (state_ff == LINK_SHIFT);
  assign status_word[`SWL_WORD_BITS-1:0]    = shift_reg_ff;
  assign status_word[`SWL_STAT_PD_POS]      = pd_act;
  assign status_word[`SWL_STAT_PR_POS]      = preset_act;
  assign status_word[`SWL_STAT_AL_POS]      = aligned;
  assign status_word[`SWL_STAT_CS_POS]      = frame_open;
  assign status_word[31:`SWL_STAT_CS_POS+1] = '0;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      variant_ff <= `SWL_CTRL_RESET;
    end else if (wr_ctrl) begin
      variant_ff <= reg_wdata[`SWL_CTRL_VAR_LSB +: 2];
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      `SWL_REG_CTRL:   rd_mux = {30'h0, variant_ff};
      `SWL_REG_STATUS: rd_mux = status_word;
      `SWL_REG_COUNT:  rd_mux = {16'h0, bit_count_ff};
      default: begin
        // the range test keeps the cut index in bounds
        if (reg_addr >= `SWL_REG_WIPER0 &&
            reg_addr < `SWL_REG_WIPER0 + 3'(CHANNELS)) begin
          rd_mux = {24'h0, latch_ff[2'(reg_addr - `SWL_REG_WIPER0)]};
        end
      end
    endcase
  end

  // data valid in the cycle after the strobe only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // serial_wiper_latch_loader

`default_nettype wire

// ===== verilog/wiper_defs.svh
/*
  Offsets, field positions, reset values and counts of the serial wiper latch loader.
  Assumes inclusion by bare name from files under verilog/.
*/
`ifndef WIPER_DEFS_SVH
`define WIPER_DEFS_SVH

// ------------------------------------------------------------
// serial word layout
// ------------------------------------------------------------
`define SWL_WORD_BITS    10
`define SWL_ADDR_HI_POS  9
`define SWL_ADDR_LO_POS  8
`define SWL_DATA_MSB     7
`define SWL_CODE_BITS    8
`define SWL_MIDSCALE     8'h80

// ------------------------------------------------------------
// register port
// ------------------------------------------------------------
`define SWL_ADDR_BITS    3
`define SWL_REG_CTRL     3'h0
`define SWL_REG_STATUS   3'h1
`define SWL_REG_WIPER0   3'h2
`define SWL_REG_COUNT    3'h6
`define SWL_CTRL_VAR_LSB 0
`define SWL_CTRL_RESET   2'h2
`define SWL_STAT_PD_POS  10
`define SWL_STAT_PR_POS  11
`define SWL_STAT_AL_POS  12
`define SWL_STAT_CS_POS  13
`define SWL_SYNC_STAGES  2

`endif

// ===== verilog/wiper_pkg.sv
/*
  Types shared by the serial wiper latch loader files.
  Assumes wiper_defs.svh is on the include path.
*/
`default_nettype none
`include "wiper_defs.svh"

package wiper_pkg;

  // pins of the three-wire link plus the two control inputs
  typedef struct packed {
    logic sclk;
    logic select_n;
    logic serial_in;
    logic preset_n;
    logic power_down_n;
  } serial_pins_t;

  typedef enum logic [1:0] {VARIANT_ONE, VARIANT_TWO, VARIANT_FOUR} variant_t;

  typedef enum {LINK_IDLE, LINK_SHIFT} link_state_t;

  typedef logic [`SWL_CODE_BITS-1:0] wiper_code_t;

endpackage

`default_nettype wire
